/* File: pkg/ecm_pkg.sv */
// Behaviour
// RULE_01: Capture and compare use the 16-bit event timer; PWM uses the 8-bit period timer.
// RULE_02: Mode 0000 turns capture, compare and PWM off and returns the module to idle.
// RULE_03: Software must not program the reserved modes 0001 and 0011, which do nothing.
// RULE_04: Mode 0010 toggles the compare pin on each timer match and sets the module flag.
// RULE_05: Mode 0100 captures the timer on each falling edge, mode 0101 on each rising edge.
// RULE_06: Mode 0110 captures on every fourth rising edge, mode 0111 on every sixteenth.
// RULE_07: In PWM the duty low field gives the two low bits of a 10-bit duty over the low byte.
// RULE_08: All eight control bits are read/write and reset to zero, leaving the module off.
// RULE_09: A new capture overwrites the held 16-bit value even if it was never read.
// RULE_10: Mode 1010 only raises the flag on a match and leaves the compare pin undriven.
// RULE_11: Mode 1011 clears the event timer on a match, without overflow, and starts the ADC.
// RULE_12: The edge prescaler clears when off, outside capture or on reset, not on a reselect.
// RULE_13: Modes 11xx select PWM; bit 1 inverts the A/C pair and bit 0 inverts the B/D pair.
package ecm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 3;
  localparam logic [2:0] ADDR_CONTROL    = 3'h0;
  localparam logic [2:0] ADDR_CC_LOW     = 3'h1;
  localparam logic [2:0] ADDR_CC_HIGH    = 3'h2;
  localparam logic [2:0] ADDR_STATUS     = 3'h3;
  localparam logic [2:0] ADDR_MASK       = 3'h4;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BRIDGE_MSB = 7;
  localparam int BRIDGE_LSB = 6;
  localparam int DUTY_MSB   = 5;
  localparam int DUTY_LSB   = 4;
  localparam int MODE_MSB   = 3;
  localparam int MODE_LSB   = 0;
  localparam int FLAG_BIT   = 0;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_RSVD_A    = 4'h1;
  localparam logic [3:0] MODE_CMP_TOG   = 4'h2;
  localparam logic [3:0] MODE_RSVD_B    = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_R4    = 4'h6;
  localparam logic [3:0] MODE_CAP_R16   = 4'h7;
  localparam logic [3:0] MODE_CMP_SET   = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI   = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC  = 4'hB;
  localparam logic [1:0] GROUP_CAPTURE  = 2'h1;
  localparam logic [1:0] GROUP_COMPARE  = 2'h2;
  localparam logic [1:0] GROUP_PWM      = 2'h3;

  // ----------------------------------------------------------------
  // bridge steering and prescaler
  // ----------------------------------------------------------------
  localparam logic [1:0] BRIDGE_SINGLE  = 2'h0;
  localparam logic [1:0] BRIDGE_FWD     = 2'h1;
  localparam logic [1:0] BRIDGE_HALF    = 2'h2;
  localparam logic [1:0] BRIDGE_REV     = 2'h3;
  localparam int         PRESC_W        = 4;
  localparam logic [1:0] PRESC_LAST4    = 2'h3;
  localparam logic [3:0] PRESC_LAST16   = 4'hF;
  localparam logic [3:0] PRESC_RESET    = 4'h0;

endpackage

/* File: pkg/ecm_presc_if.sv */
`timescale 1ns/10ps
// carries the edge prescaler handshake between top and counter
interface ecm_presc_if;
  logic                        clr;
  logic                        rise;
  logic [ecm_pkg::PRESC_W-1:0] count;
  modport ctl (output clr, output rise, input count);
  modport cnt (input clr, input rise, output count);
endinterface

/* File: design/ecm_edge_prescaler.sv */
`timescale 1ns/10ps
module ecm_edge_prescaler (
  input  wire logic clk,
  input  wire logic sys_rst,
  ecm_presc_if.cnt  pif
);

  // ----------------------------------------------------------------
  // rising edge counter
  // ----------------------------------------------------------------
  logic [ecm_pkg::PRESC_W-1:0] count_r;
  logic [ecm_pkg::PRESC_W-1:0] count_nxt;

  // wraps freely, so a change of divide ratio keeps the count
  always_comb begin
    count_nxt = count_r;
    if (pif.clr) begin
      count_nxt = ecm_pkg::PRESC_RESET;        // see RULE_12
    end else if (pif.rise) begin
      count_nxt = count_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= ecm_pkg::PRESC_RESET;         // see RULE_12
    end else begin
      count_r <= count_nxt;
    end
  end

  assign pif.count = count_r;

endmodule

/* File: design/ecm_top.sv */
`timescale 1ns/10ps
module ecm_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        event_pin_i,
  output logic             event_pin_o,
  output logic             event_pin_oe,
  input  wire logic [15:0] event_timer_16,
  input  wire logic [7:0]  period_timer_8,
  input  wire logic [1:0]  period_timer_frac,
  input  wire logic        period_restart,
  output logic             bridge_out_a,
  output logic             bridge_out_b,
  output logic             bridge_out_c,
  output logic             bridge_out_d,
  output logic             bridge_oe_a,
  output logic             bridge_oe_b,
  output logic             bridge_oe_c,
  output logic             bridge_oe_d,
  output logic             timer_clear,
  output logic             adc_start,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] cc_lo_r;
  logic [7:0] cc_lo_nxt;
  logic [7:0] cc_hi_r;
  logic [7:0] cc_hi_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       mask_r;
  logic       mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic       pin_meta_r;
  logic       pin_sync_r;
  logic       pin_prev_r;
  logic       eq_prev_r;
  logic       eq_prev_nxt;
  logic       cmp_out_r;
  logic       cmp_out_nxt;
  logic       pin_oe_r;
  logic       pin_oe_nxt;
  logic       tclr_r;
  logic       tclr_nxt;
  logic       adc_r;
  logic       adc_nxt;
  logic [9:0] duty_r;
  logic [9:0] duty_nxt;
  logic [3:0] bout_r;
  logic [3:0] bout_nxt;
  logic [3:0] boe_r;
  logic [3:0] boe_nxt;
  logic [3:0] mode;
  logic       is_off;
  logic       is_cap;
  logic       is_cmp;
  logic       is_pwm;
  logic       rise;
  logic       fall;
  logic       cap_hit;
  logic       cmp_eq;
  logic       cmp_hit;
  logic       pwm_raw;

  ecm_presc_if pif ();

  ecm_edge_prescaler u_presc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pif     (pif)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // reserved codes fall in no group and so leave every action idle
  always_comb begin
    mode   = ctrl_r[ecm_pkg::MODE_MSB:ecm_pkg::MODE_LSB];
    is_off = (mode == ecm_pkg::MODE_OFF);                          // see RULE_02
    is_cap = (mode[3:2] == ecm_pkg::GROUP_CAPTURE);
    is_cmp = (mode == ecm_pkg::MODE_CMP_TOG) ||
             (mode[3:2] == ecm_pkg::GROUP_COMPARE);
    is_pwm = (mode[3:2] == ecm_pkg::GROUP_PWM);                    // see RULE_13
  end

  // ----------------------------------------------------------------
  // event pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // meta stage feeds only the sync stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= event_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // capture trigger
  // ----------------------------------------------------------------
  always_comb begin
    rise     = pin_sync_r & ~pin_prev_r;
    fall     = ~pin_sync_r & pin_prev_r;
    pif.clr  = ~is_cap;                                            // see RULE_12
    pif.rise = rise & is_cap;
    case (mode)
      ecm_pkg::MODE_CAP_FALL: cap_hit = fall;                      // see RULE_05
      ecm_pkg::MODE_CAP_RISE: cap_hit = rise;                      // see RULE_05
      ecm_pkg::MODE_CAP_R4:   cap_hit = rise &&
                                (pif.count[1:0] == ecm_pkg::PRESC_LAST4);  // see RULE_06
      ecm_pkg::MODE_CAP_R16:  cap_hit = rise &&
                                (pif.count == ecm_pkg::PRESC_LAST16);      // see RULE_06
      default:                cap_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // compare match
  // ----------------------------------------------------------------
  // only the first cycle of equality counts, a stalled timer gives one event
  always_comb begin
    cmp_eq      = (event_timer_16 == {cc_hi_r, cc_lo_r});          // see RULE_01
    cmp_hit     = is_cmp & cmp_eq & ~eq_prev_r;
    eq_prev_nxt = is_cmp & cmp_eq;
    cmp_out_nxt = cmp_out_r;
    if (is_off) begin
      cmp_out_nxt = 1'b0;                                          // see RULE_02
    end else if (cmp_hit) begin
      case (mode)
        ecm_pkg::MODE_CMP_TOG: cmp_out_nxt = ~cmp_out_r;           // see RULE_04
        ecm_pkg::MODE_CMP_SET: cmp_out_nxt = 1'b1;
        ecm_pkg::MODE_CMP_CLR: cmp_out_nxt = 1'b0;
        default:               cmp_out_nxt = cmp_out_r;
      endcase
    end
    pin_oe_nxt = is_cmp && (mode != ecm_pkg::MODE_CMP_SWI);        // see RULE_10
    tclr_nxt   = cmp_hit && (mode == ecm_pkg::MODE_CMP_SPEC);      // see RULE_11
    adc_nxt    = cmp_hit && (mode == ecm_pkg::MODE_CMP_SPEC);      // see RULE_11
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eq_prev_r <= 1'b0;
      cmp_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
      tclr_r    <= 1'b0;
      adc_r     <= 1'b0;
    end else begin
      eq_prev_r <= eq_prev_nxt;
      cmp_out_r <= cmp_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      tclr_r    <= tclr_nxt;
      adc_r     <= adc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register file, flag and interrupt
  // ----------------------------------------------------------------
  // hardware set wins over the one-to-clear write in the same cycle
  always_comb begin
    ctrl_nxt  = ctrl_r;
    cc_lo_nxt = cc_lo_r;
    cc_hi_nxt = cc_hi_r;
    flag_nxt  = flag_r;
    mask_nxt  = mask_r;
    rdata_nxt = ecm_pkg::READ_UNMAPPED;
    if (reg_wr) begin
      case (reg_addr)
        ecm_pkg::ADDR_CONTROL: ctrl_nxt  = reg_wdata;              // see RULE_08
        ecm_pkg::ADDR_CC_LOW:  cc_lo_nxt = reg_wdata;
        ecm_pkg::ADDR_CC_HIGH: cc_hi_nxt = reg_wdata;
        ecm_pkg::ADDR_STATUS:  if (reg_wdata[ecm_pkg::FLAG_BIT]) begin
          flag_nxt = 1'b0;
        end
        ecm_pkg::ADDR_MASK:    mask_nxt  = reg_wdata[ecm_pkg::FLAG_BIT];
        default:               ctrl_nxt  = ctrl_r;
      endcase
    end
    if (cap_hit) begin
      {cc_hi_nxt, cc_lo_nxt} = event_timer_16;                     // see RULE_09
    end
    if (cap_hit | cmp_hit) begin
      flag_nxt = 1'b1;                                             // see RULE_04
    end
    if (reg_rd) begin
      case (reg_addr)
        ecm_pkg::ADDR_CONTROL: rdata_nxt = ctrl_r;                 // see RULE_08
        ecm_pkg::ADDR_CC_LOW:  rdata_nxt = cc_lo_r;
        ecm_pkg::ADDR_CC_HIGH: rdata_nxt = cc_hi_r;
        ecm_pkg::ADDR_STATUS:  rdata_nxt = {7'h00, flag_r};
        ecm_pkg::ADDR_MASK:    rdata_nxt = {7'h00, mask_r};
        default:               rdata_nxt = ecm_pkg::READ_UNMAPPED;
      endcase
    end
    irq_nxt = flag_nxt & mask_nxt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r  <= ecm_pkg::CONTROL_RESET;                           // see RULE_08
      cc_lo_r <= 8'h00;
      cc_hi_r <= 8'h00;
      flag_r  <= 1'b0;
      mask_r  <= 1'b0;
      rdata_r <= ecm_pkg::READ_UNMAPPED;
      irq_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cc_lo_r <= cc_lo_nxt;
      cc_hi_r <= cc_hi_nxt;
      flag_r  <= flag_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pwm duty and bridge steering
  // ----------------------------------------------------------------
  // duty reloads only at a period start so a period never sees half an update
  always_comb begin
    logic [3:0] act;
    act      = 4'h0;
    duty_nxt = duty_r;
    if (!is_pwm) begin
      duty_nxt = 10'h000;
    end else if (period_restart) begin
      duty_nxt = {cc_lo_r, ctrl_r[ecm_pkg::DUTY_MSB:ecm_pkg::DUTY_LSB]};  // see RULE_07
    end
    pwm_raw = ({period_timer_8, period_timer_frac} < duty_r);      // see RULE_01
    boe_nxt = 4'h0;
    if (is_pwm) begin
      case (ctrl_r[ecm_pkg::BRIDGE_MSB:ecm_pkg::BRIDGE_LSB])
        ecm_pkg::BRIDGE_SINGLE: begin
          act     = {3'h0, pwm_raw};
          boe_nxt = 4'h1;
        end
        ecm_pkg::BRIDGE_FWD: begin
          act     = {pwm_raw, 2'h0, 1'b1};
          boe_nxt = 4'hF;
        end
        ecm_pkg::BRIDGE_HALF: begin
          act     = {2'h0, ~pwm_raw, pwm_raw};
          boe_nxt = 4'h3;
        end
        ecm_pkg::BRIDGE_REV: begin
          act     = {1'b0, 1'b1, pwm_raw, 1'b0};
          boe_nxt = 4'hF;
        end
        default: begin
          act     = 4'h0;
          boe_nxt = 4'h0;
        end
      endcase
    end
    // bit order d,c,b,a; polarity only applies while in pwm
    bout_nxt = act ^ ({4{is_pwm}} & {mode[ecm_pkg::POL_BD_BIT],
                                     mode[ecm_pkg::POL_AC_BIT],
                                     mode[ecm_pkg::POL_BD_BIT],
                                     mode[ecm_pkg::POL_AC_BIT]});  // see RULE_13
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_r <= 10'h000;
      bout_r <= 4'h0;
      boe_r  <= 4'h0;
    end else begin
      duty_r <= duty_nxt;
      bout_r <= bout_nxt;
      boe_r  <= boe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = rdata_r;
  assign event_pin_o  = cmp_out_r;
  assign event_pin_oe = pin_oe_r;
  assign bridge_out_a = bout_r[0];
  assign bridge_out_b = bout_r[1];
  assign bridge_out_c = bout_r[2];
  assign bridge_out_d = bout_r[3];
  assign bridge_oe_a  = boe_r[0];
  assign bridge_oe_b  = boe_r[1];
  assign bridge_oe_c  = boe_r[2];
  assign bridge_oe_d  = boe_r[3];
  assign timer_clear  = tclr_r;
  assign adc_start    = adc_r;
  assign irq          = irq_r;

endmodule

/* File: bench/ecm_partner.sv */
`timescale 1ns/10ps
// ------------------------------------------
// event source on the two-way event pin
// ------------------------------------------
module ecm_partner (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_i
);
  logic src;

  // device wins while it drives, else the source level
  assign pin_i = pin_oe ? pin_o : src;

  initial src = 1'b0;

  // held six cycles so the two-flop sync never drops it
  task automatic edge_to(input logic lvl);
    @(posedge clk);
    src <= lvl;
    repeat (6) @(posedge clk);
  endtask

  // one rising then one falling edge
  task automatic pulse;
    edge_to(1'b1);
    edge_to(1'b0);
  endtask
endmodule

/* File: bench/ecm_top_monitor.sv */
`timescale 1ns/10ps
module ecm_top_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       event_pin_oe,
  input wire logic       bridge_oe_a,
  input wire logic       bridge_oe_b,
  input wire logic       bridge_oe_c,
  input wire logic       bridge_oe_d,
  input wire logic       timer_clear,
  input wire logic       adc_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------
  // bus steps
  // ------------------------------------------
  sequence s_ctl_wr;
    reg_wr && reg_addr == ecm_pkg::ADDR_CONTROL;
  endsequence
  sequence s_ctl_rd;
    reg_rd && reg_addr == ecm_pkg::ADDR_CONTROL;
  endsequence
  sequence s_off_wr;
    s_ctl_wr ##0 reg_wdata[3:0] == ecm_pkg::MODE_OFF;
  endsequence

  a_ctl_readback:
    assert property (s_ctl_wr ##1 !reg_wr ##1 s_ctl_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control readback differs from write");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero:
    assert property (reg_rd && reg_addr > ecm_pkg::ADDR_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_off_releases:
    assert property (s_off_wr |-> ##2 !(event_pin_oe || bridge_oe_a || bridge_oe_b))
    else $error("pins still driven after mode off");
  a_special_pair:
    assert property (timer_clear || adc_start |-> timer_clear && adc_start)
    else $error("timer clear and adc start apart");
  a_special_once:
    assert property (timer_clear |=> !timer_clear)
    else $error("timer clear longer than one cycle");
  a_special_pin:
    assert property (adc_start |-> event_pin_oe && !bridge_oe_a)
    else $error("special event without compare pin drive");
  a_pin_excl:
    assert property (!(event_pin_oe && (bridge_oe_a || bridge_oe_b)))
    else $error("compare pin and bridge driven together");
  a_full_bridge:
    assert property (bridge_oe_c |-> bridge_oe_a && bridge_oe_b && bridge_oe_d)
    else $error("full bridge enables incomplete");
  a_half_bridge:
    assert property (bridge_oe_b |-> bridge_oe_a)
    else $error("bridge b driven without a");
endmodule

bind ecm_top ecm_top_monitor ecm_top_monitor_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_pin_oe(event_pin_oe),
  .bridge_oe_a(bridge_oe_a), .bridge_oe_b(bridge_oe_b), .bridge_oe_c(bridge_oe_c),
  .bridge_oe_d(bridge_oe_d), .timer_clear(timer_clear), .adc_start(adc_start));

/* File: bench/tb_enhanced_ccp_mode_control.sv */
`timescale 1ns/10ps
module tb_enhanced_ccp_mode_control;
  logic        clk, sys_rst, reg_wr, reg_rd, ev_o, ev_oe, ev_i;
  logic        restart, tclr, adc, irq;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ptmr, rv;
  logic [1:0]  pfrac;
  logic [15:0] tmr;
  logic [3:0]  bout, boe;
  int          fails, check_count, cyc, tclr_n, adc_n;
  // {oe, pin, mode}; reserved codes never written
  logic [5:0]  cw [5] = '{6'h32, 6'h29, 6'h38, 6'h3B, 6'h0A};
  // {control, oe dcba, out dcba} at pwm high
  // last entry inverts only the b/d pair, so a swapped polarity pair shows
  logic [15:0] pw [6] = '{16'h2C11, 16'h6CF9, 16'hAC31, 16'hECF6, 16'hEFF9, 16'hEDFC};

  ecm_top ecm_top_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_pin_i(ev_i),
    .event_pin_o(ev_o), .event_pin_oe(ev_oe), .event_timer_16(tmr),
    .period_timer_8(ptmr), .period_timer_frac(pfrac), .period_restart(restart),
    .bridge_out_a(bout[0]), .bridge_out_b(bout[1]), .bridge_out_c(bout[2]),
    .bridge_out_d(bout[3]), .bridge_oe_a(boe[0]), .bridge_oe_b(boe[1]),
    .bridge_oe_c(boe[2]), .bridge_oe_d(boe[3]), .timer_clear(tclr),
    .adc_start(adc), .irq(irq));
  ecm_partner ecm_partner_i (.clk(clk), .pin_o(ev_o), .pin_oe(ev_oe), .pin_i(ev_i));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // special event pulses and hang guard
  always @(posedge clk) begin
    cyc++;
    if (tclr === 1'b1) tclr_n++;
    if (adc === 1'b1) adc_n++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ------------------------------------------
  // bus and compare tasks
  // ------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // level outputs: the value is taken at the call, so callers settle first
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic chk_reg(input string n, input logic [2:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(n, {8'h00, e}, {8'h00, rv});
  endtask
  task automatic set_tmr(input logic [15:0] v);
    @(posedge clk);
    tmr <= v;
  endtask
  task automatic restart_pwm;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask
  task automatic presc_run(input int n);
    for (int i = 1; i <= n; i++) begin
      ecm_partner_i.pulse();
      rd(ecm_pkg::ADDR_STATUS, rv);
      chk("presc_flag", 16'(i == n), {15'h0000, rv[0]});
    end
    wr(ecm_pkg::ADDR_STATUS, 8'h01);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------
  // test sequence
  // ------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, restart, reg_addr, reg_wdata, tmr, pfrac} = '0;
    ptmr  = 8'h40;
    pfrac = 2'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reg("ctl_reset", ecm_pkg::ADDR_CONTROL, ecm_pkg::CONTROL_RESET);
    wr(ecm_pkg::ADDR_CONTROL, 8'hF0);
    chk_reg("ctl_rw", ecm_pkg::ADDR_CONTROL, 8'hF0);
    repeat (2) @(negedge clk);
    chk_bit("off_oe", 1'b0, |boe);
    chk_reg("unmapped", 3'h7, 8'h00);
    wr(ecm_pkg::ADDR_MASK, 8'h01);
    $display("test registers done");
    // capture edges, mask and overwrite
    wr(ecm_pkg::ADDR_CONTROL, {4'h0, ecm_pkg::MODE_CAP_RISE});
    set_tmr(16'h1234);
    ecm_partner_i.edge_to(1'b1);
    chk_reg("cap_lo", ecm_pkg::ADDR_CC_LOW, 8'h34);
    chk_reg("cap_hi", ecm_pkg::ADDR_CC_HIGH, 8'h12);
    repeat (2) @(negedge clk);
    chk_bit("cap_irq", 1'b1, irq);
    wr(ecm_pkg::ADDR_MASK, 8'h00);
    repeat (2) @(negedge clk);
    chk_bit("mask_irq", 1'b0, irq);
    wr(ecm_pkg::ADDR_MASK, 8'h01);
    set_tmr(16'hBEEF);
    ecm_partner_i.edge_to(1'b0);
    chk_reg("cap_keep", ecm_pkg::ADDR_CC_HIGH, 8'h12);
    ecm_partner_i.edge_to(1'b1);
    chk_reg("cap_over", ecm_pkg::ADDR_CC_HIGH, 8'hBE);
    wr(ecm_pkg::ADDR_STATUS, 8'h01);
    repeat (2) @(negedge clk);
    chk_bit("irq_clear", 1'b0, irq);
    wr(ecm_pkg::ADDR_CONTROL, {4'h0, ecm_pkg::MODE_CAP_FALL});
    set_tmr(16'h5A5A);
    ecm_partner_i.edge_to(1'b0);
    chk_reg("cap_fall", ecm_pkg::ADDR_CC_LOW, 8'h5A);
    $display("test capture done");
    // prescaler kept across reselect, cleared when off
    wr(ecm_pkg::ADDR_CONTROL, 8'h00);
    wr(ecm_pkg::ADDR_STATUS, 8'h01);
    wr(ecm_pkg::ADDR_CONTROL, {4'h0, ecm_pkg::MODE_CAP_R4});
    presc_run(4);
    wr(ecm_pkg::ADDR_CONTROL, {4'h0, ecm_pkg::MODE_CAP_R16});
    presc_run(12);
    // leave the count at one so only a clear on off gives the fourth-edge hit
    ecm_partner_i.pulse();
    wr(ecm_pkg::ADDR_CONTROL, 8'h00);
    wr(ecm_pkg::ADDR_CONTROL, {4'h0, ecm_pkg::MODE_CAP_R4});
    presc_run(4);
    $display("test prescaler done");
    // compare actions; equality held five cycles gives one event
    set_tmr(16'h0000);
    wr(ecm_pkg::ADDR_CC_HIGH, 8'h00);
    wr(ecm_pkg::ADDR_CC_LOW, 8'h10);
    for (int i = 0; i < 5; i++) begin
      wr(ecm_pkg::ADDR_CONTROL, {4'h0, cw[i][3:0]});
      wr(ecm_pkg::ADDR_STATUS, 8'h01);
      set_tmr(16'h0010);
      repeat (4) @(posedge clk);
      set_tmr(16'h0000);
      chk("cmp_pin", {14'h0, cw[i][5:4]}, {14'h0, ev_oe, ev_o & ev_oe});
      chk_reg("cmp_flag", ecm_pkg::ADDR_STATUS, 8'h01);
    end
    chk("special", 16'h0101, {tclr_n[7:0], adc_n[7:0]});
    wr(ecm_pkg::ADDR_CONTROL, 8'h00);
    repeat (2) @(negedge clk);
    chk_bit("off_latch", 1'b0, ev_o | ev_oe);
    $display("test compare done");
    // pwm steering and polarity, timer just below duty 0x102
    wr(ecm_pkg::ADDR_CC_LOW, 8'h40);
    for (int i = 0; i < 6; i++) begin
      wr(ecm_pkg::ADDR_CONTROL, pw[i][15:8]);
      restart_pwm();
      repeat (3) @(posedge clk);
      chk("bridge", {8'h00, pw[i][7:0]}, {8'h00, boe, bout & boe});
    end
    wr(ecm_pkg::ADDR_CONTROL, 8'h2C);
    restart_pwm();
    @(posedge clk);
    pfrac <= 2'h2;
    repeat (3) @(posedge clk);
    chk("duty_edge", 16'h0000, {15'h0000, bout[0]});
    $display("test pwm done");
    results();
  end
endmodule
